/* File: core/idc_pkg.sv */
// Purpose: shared constants for the interrupt dispatch and core state unit
// Assumes: 24-bit core, eight priority-ordered arbitrated interrupt sources
// Notes: status word and mode register field positions are local choices
package idc_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned SP_W = 4;
  // status word fields
  localparam int unsigned SW_CARRY = 0;
  localparam int unsigned SW_CCR_W = 8;
  localparam int unsigned SW_IMASK_LO = 8;
  localparam int unsigned SW_IMASK_HI = 9;
  localparam int unsigned SW_SCALE_LO = 10;
  localparam int unsigned SW_SCALE_HI = 11;
  localparam int unsigned SW_SIXTEEN = 13;
  localparam int unsigned SW_DPREC = 14;
  localparam int unsigned SW_LOOP = 15;
  localparam int unsigned SW_CACHE = 19;
  localparam logic [23:0] SW_RESET = 24'h00_0300;
  // operating mode register fields
  localparam int unsigned OMR_MODE_LO = 0;
  localparam int unsigned OMR_BURST = 7;
  localparam logic [23:0] OMR_RESET = 24'h00_0000;
  localparam logic [23:0] MOD_RESET = 24'h0F_FFFF;
  localparam logic [23:0] BUS_TIMING_RESET = 24'h1F_FFFF;
  localparam logic [23:0] ATTR_RESET = 24'h00_0000;
  localparam logic [23:0] DRAM_TIMING_RESET = 24'h00_0000;
  localparam logic [23:0] ZERO_WORD = 24'h00_0000;
  localparam logic [23:0] ONE_WORD = 24'h00_0001;
  // each source owns a two-word slot
  localparam logic [23:0] SLOT_STRIDE = 24'h00_0002;
  localparam logic [1:0] IPL_NMI = 2'h3;
  typedef enum logic [2:0] {
    IDC_RESET, IDC_RUN, IDC_VEC1, IDC_VEC2, IDC_WAIT, IDC_DEBUG
  } idc_state_t;
endpackage

/* File: core/idc_core.sv */
// Purpose: inserts interrupt vector fetches and sequences reset, run, wait and debug states
// Assumes: decode reports instruction completion, change of flow and executed opcodes
// Notes: arbitration below ipl 3 is masked by the status word; level 3 is never masked, lowest index wins
//   vector words are flagged in the same cycle that their address is shown
//   stack arrays are not reset; pointer and depth say which entries are valid
//   stack overflow is not detected, so software must keep nesting shallow
//   debug state is left only through the reset pin
//   discard_cnt only reports drops; the pipeline does the dropping
`timescale 1ns/1ps
`default_nettype none

// Operation
// - accepted interrupt fetches from vector address, then vector address plus one
// - program counter held during the two vector fetches, then used again
// - fast interrupt runs exactly two inserted words and resumes without return
// - slot holds two one-word instructions or a single two-word instruction
// - long interrupt discards second word, next prefetch and two post-return words
// - fast interrupt saves no status word or other status
// - program counter keeps next normal address through a fast interrupt
// - no interrupt accepted while fast interrupt words are handled
// - subroutine jump in either vector word forms a long interrupt
// - long-forming jump stacks counter and status, raises mask, clears loop, scaling
// - long service routine stays interruptible only by levels above its own level plus one, and by level 3
// - return from interrupt pops counter and status, resumes at restored address
// - repeat pair is one instruction; fetch and interrupts held until count one
// - reset pin enters reset state, clears priorities, stack pointer, depth and vector base
// - all eight address modifiers load the value 0F_FFFF on reset
// - reset clears status bits and burst bit and sets the interrupt mask
// - bus timing takes maximum wait-state values on reset; attribute and dram timing clear to zero
// - stay in reset while pin low; on release load mode from boot pins
// - wait instruction gates core clock except peripherals
// - wait exits on unmasked interrupt, reset or break pin; break enters debug
// - chosen pending flag stays set until its second vector word fetches
// - arbitration after each instruction compares pending against status mask
module idc_core (
  input wire logic clk_sys, // core clock
  input wire logic rst_n, // reset pin, active low
  input wire logic [3:0] boot_select_pins, // operating mode straps
  input wire logic emulation_break_pin_n, // debug break, active low
  input wire logic [7:0] irq_req, // arbitrated sources, bit 0 highest
  input wire logic [15:0] irq_ipl, // two-bit level per source
  input wire logic fetch_ack, // fetch slot consumed this cycle
  input wire logic instr_done, // an instruction finished execution
  input wire logic exec_jsr, // executing subroutine jump
  input wire logic jsr_from_slot, // that jump came from a vector word
  input wire logic exec_rti, // executing return from interrupt
  input wire logic exec_wait, // executing wait instruction
  input wire logic exec_rep, // repeat instruction entered
  input wire logic [23:0] rep_count, // repeat count
  input wire logic slot_two_word, // first vector word is a two-word instruction
  input wire logic [23:0] next_pc_in, // pipeline's next program counter value
  input wire logic pc_load, // pipeline loads program counter
  input wire logic [7:0] prio_core_wr, // core priority register write data
  input wire logic prio_core_we, // write strobe
  input wire logic [23:0] vbase_wr, // vector base write data
  input wire logic vbase_we, // write strobe
  output logic [23:0] fetch_addr, // address for the next fetch
  output logic fetch_from_vector, // fetch is an inserted vector word
  output logic [23:0] program_counter, // normal-flow counter
  output logic [23:0] processor_status_word, // status word
  output logic [23:0] operating_mode_register, // mode register
  output logic [23:0] loop_counter, // repeat counter
  output logic [4:0] discard_cnt, // words still to discard
  output logic [3:0] stack_pointer, // stack pointer
  output logic [4:0] stack_depth_counter, // stack depth
  output logic [23:0] vector_base_register, // vector base
  output logic [7:0] core_priority_register, // core priorities
  output logic [7:0] peripheral_priority_register, // peripheral priorities
  output logic [23:0] bus_timing_control, // bus timing
  output logic [23:0] address_attribute_regs, // attribute regs, one value
  output logic [23:0] dram_timing_control, // dram timing
  output logic [23:0] address_modifier_regs, // all eight modifiers share reset value
  output logic periph_rst, // peripherals held reset
  output logic core_clk_en, // core clock gate
  output logic debug_mode, // debug state entered
  output logic [7:0] pending_ack // pending flag clear pulses
);
  idc_pkg::idc_state_t state;
  logic [7:0] pending;
  logic [2:0] chosen;
  logic [23:0] vec_addr;
  logic fast_active;
  logic accept; // interrupt taken at this edge
  // return stack: entry zero is written only by the sixteenth push, the first push lands at one
  // pointer and depth move together; depth is wider so a full stack shows 16
  logic [23:0] stk_pc [0:15];
  logic [23:0] stk_sw [0:15];
  logic rep_active;
  logic boot_load;
  logic [7:0] allowed;
  logic any_allowed;
  logic [2:0] sel;
  logic [1:0] imask;

  function automatic logic [23:0] slot_addr(input logic [23:0] base, input logic [2:0] src);
    slot_addr = base + idc_pkg::SLOT_STRIDE * {21'h0, src};
  endfunction

  assign imask = processor_status_word[idc_pkg::SW_IMASK_HI:idc_pkg::SW_IMASK_LO];

  // timing of one dispatch, edge by edge:
  //   e0 run, instr_done with an allowed request: fetch_addr takes the slot
  //   e1 first word consumed: fetch_addr moves to slot plus one
  //   e2 second word consumed: fetch_addr returns to the counter,
  //      the chosen pending flag clears and pending_ack pulses
  //   without fetch_ack each step waits, holding its address
  // the counter is frozen until the fast window closes, so a fast
  // routine returns to exactly the word it interrupted

  // accept only at an instruction boundary, outside repeat and fast windows
  assign accept = state == idc_pkg::IDC_RUN && instr_done && any_allowed && !rep_active
                  && !fast_active;

  // mask compare: level 3 always allowed, else level must exceed mask
  // lowest index wins among allowed sources, so the scan runs downwards
  always_comb begin
    allowed = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (pending[i] && (irq_ipl[2*i +: 2] == idc_pkg::IPL_NMI || irq_ipl[2*i +: 2] > imask)) begin
        allowed[i] = 1'b1;
      end
    end
    any_allowed = |allowed;
    sel = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (allowed[i]) begin
        sel = 3'(i);
      end
    end
  end

  // pending flags: clear wins over set; chosen flag held until second vector fetch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 8'h00;
      pending_ack <= 8'h00;
    end else begin
      pending_ack <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        if (state == idc_pkg::IDC_VEC2 && fetch_ack && chosen == 3'(i)) begin
          pending[i] <= 1'b0;
          pending_ack[i] <= 1'b1;
        end else if (irq_req[i]) begin
          pending[i] <= 1'b1;
        end
      end
    end
  end

  // state sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= idc_pkg::IDC_RESET;
      chosen <= 3'h0;
      vec_addr <= idc_pkg::ZERO_WORD;
      boot_load <= 1'b0;
    end else begin
      boot_load <= 1'b0;
      unique case (state)
        idc_pkg::IDC_RESET: begin
          state <= idc_pkg::IDC_RUN;
          boot_load <= 1'b1;
        end
        idc_pkg::IDC_RUN: begin
          if (exec_wait) begin
            state <= idc_pkg::IDC_WAIT;
          end else if (accept) begin
            state <= idc_pkg::IDC_VEC1;
            chosen <= sel;
            vec_addr <= slot_addr(vector_base_register, sel);
          end
        end
        idc_pkg::IDC_VEC1: begin
          if (fetch_ack) begin
            state <= idc_pkg::IDC_VEC2;
          end
        end
        idc_pkg::IDC_VEC2: begin
          if (fetch_ack) begin
            state <= idc_pkg::IDC_RUN;
          end
        end
        idc_pkg::IDC_WAIT: begin
          if (!emulation_break_pin_n) begin
            state <= idc_pkg::IDC_DEBUG;
          end else if (any_allowed) begin
            state <= idc_pkg::IDC_RUN;
          end
        end
        idc_pkg::IDC_DEBUG: begin
          state <= idc_pkg::IDC_DEBUG;
        end
      endcase
    end
  end

  // fast interrupt window: vector words in flight until two retire or a jump forms long
  // the second word retires back in run state, so it is counted there
  logic [1:0] fast_left;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fast_active <= 1'b0;
      fast_left <= 2'h0;
    end else if (state == idc_pkg::IDC_VEC1 && fetch_ack) begin
      fast_active <= 1'b1;
      fast_left <= slot_two_word ? 2'h1 : 2'h2;
    end else if (fast_active && exec_jsr && jsr_from_slot) begin
      fast_active <= 1'b0;
    end else if (fast_active && instr_done && state != idc_pkg::IDC_VEC2) begin
      fast_left <= fast_left - 2'h1;
      if (fast_left == 2'h1) begin
        fast_active <= 1'b0;
      end
    end
  end

  // fetch address mux registered for the next fetch slot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr <= idc_pkg::ZERO_WORD;
      fetch_from_vector <= 1'b0;
    end else begin
      unique case (state)
        idc_pkg::IDC_VEC1: begin
          fetch_addr <= fetch_ack ? vec_addr + idc_pkg::ONE_WORD : vec_addr;
          fetch_from_vector <= 1'b1;
        end
        idc_pkg::IDC_VEC2: begin
          fetch_addr <= fetch_ack ? program_counter : vec_addr + idc_pkg::ONE_WORD;
          fetch_from_vector <= !fetch_ack;
        end
        default: begin
          // flag rides with the first vector address so the pipeline tags it
          fetch_addr <= accept ? slot_addr(vector_base_register, sel) : program_counter;
          fetch_from_vector <= accept;
        end
      endcase
    end
  end

  // program counter, status word and stack
  // only the slot jump stacks; a jump in normal code moves the counter by pc_load
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_counter <= idc_pkg::ZERO_WORD;
      processor_status_word <= idc_pkg::SW_RESET;
      stack_pointer <= 4'h0;
      stack_depth_counter <= 5'h00;
    end else if (exec_jsr && jsr_from_slot) begin
      stk_pc[stack_pointer + 4'h1] <= program_counter;
      stk_sw[stack_pointer + 4'h1] <= processor_status_word;
      stack_pointer <= stack_pointer + 4'h1;
      stack_depth_counter <= stack_depth_counter + 5'h01;
      program_counter <= next_pc_in;
      processor_status_word[idc_pkg::SW_IMASK_HI:idc_pkg::SW_IMASK_LO] <=
        (irq_ipl[2*chosen +: 2] == idc_pkg::IPL_NMI) ? 2'h3 : irq_ipl[2*chosen +: 2] + 2'h1;
      processor_status_word[idc_pkg::SW_LOOP] <= 1'b0;
      processor_status_word[idc_pkg::SW_SCALE_HI:idc_pkg::SW_SCALE_LO] <= 2'h0;
      processor_status_word[idc_pkg::SW_SIXTEEN] <= 1'b0;
    end else if (exec_rti) begin
      program_counter <= stk_pc[stack_pointer];
      processor_status_word <= stk_sw[stack_pointer];
      stack_pointer <= stack_pointer - 4'h1;
      stack_depth_counter <= stack_depth_counter - 5'h01;
    end else if (pc_load && !fast_active && state != idc_pkg::IDC_VEC1
                 && state != idc_pkg::IDC_VEC2 && !rep_active && core_clk_en) begin
      program_counter <= next_pc_in;
    end
  end

  // long interrupt discards: second word, next prefetch, two words after return
  // counts fetches, not cycles, so a stalling pipeline drops the right words
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      discard_cnt <= 5'h00;
    end else if (exec_jsr && jsr_from_slot) begin
      discard_cnt <= 5'h02;
    end else if (exec_rti) begin
      discard_cnt <= 5'h02;
    end else if (discard_cnt != 5'h00 && fetch_ack) begin
      discard_cnt <= discard_cnt - 5'h01;
    end
  end

  // repeat: fetch and interrupts suspended until loop counter reaches one
  // count one is the last pass: interrupts may be taken after it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rep_active <= 1'b0;
      loop_counter <= idc_pkg::ZERO_WORD;
    end else if (exec_rep) begin
      rep_active <= rep_count > idc_pkg::ONE_WORD;
      loop_counter <= rep_count;
    end else if (rep_active && instr_done) begin
      loop_counter <= loop_counter - idc_pkg::ONE_WORD;
      if (loop_counter == 24'h00_0002) begin
        rep_active <= 1'b0;
      end
    end
  end

  // control registers initialised in reset state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      operating_mode_register <= idc_pkg::OMR_RESET;
      vector_base_register <= idc_pkg::ZERO_WORD;
      core_priority_register <= 8'h00;
      peripheral_priority_register <= 8'h00;
      bus_timing_control <= idc_pkg::BUS_TIMING_RESET;
      address_attribute_regs <= idc_pkg::ATTR_RESET;
      dram_timing_control <= idc_pkg::DRAM_TIMING_RESET;
      address_modifier_regs <= idc_pkg::MOD_RESET;
    end else begin
      if (boot_load) begin
        operating_mode_register[idc_pkg::OMR_MODE_LO +: 4] <= boot_select_pins;
      end
      if (vbase_we) begin
        vector_base_register <= vbase_wr;
      end
      if (prio_core_we) begin
        core_priority_register <= prio_core_wr;
      end
    end
  end

  // clock gating and debug indication
  // gate drops on the edge that executes wait and rises with the exit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      periph_rst <= 1'b1;
      core_clk_en <= 1'b0;
      debug_mode <= 1'b0;
    end else begin
      periph_rst <= 1'b0;
      core_clk_en <= !(state == idc_pkg::IDC_WAIT && emulation_break_pin_n && !any_allowed)
                     && !(state == idc_pkg::IDC_RUN && exec_wait);
      debug_mode <= debug_mode || (state == idc_pkg::IDC_WAIT && !emulation_break_pin_n);
    end
  end
endmodule // idc_core

`default_nettype wire

/* File: bench/idc_core_asserts.sv */
// Purpose: port-level checks on the interrupt dispatch unit
// Assumes: single clock domain, asynchronous active-low reset
// Notes: vec_word tracks which of the two vector words is in flight
`timescale 1ns/1ps
`default_nettype none
module idc_core_asserts (
  input wire logic clk_sys, // core clock
  input wire logic rst_n, // reset, active low
  input wire logic emulation_break_pin_n, // break, active low
  input wire logic fetch_ack, // fetch consumed
  input wire logic exec_jsr, // subroutine jump
  input wire logic jsr_from_slot, // jump from vector word
  input wire logic exec_rti, // return from interrupt
  input wire logic exec_wait, // wait instruction
  input wire logic [23:0] fetch_addr, // next fetch address
  input wire logic fetch_from_vector, // vector fetch
  input wire logic [23:0] program_counter, // normal counter
  input wire logic [23:0] processor_status_word, // status word
  input wire logic [23:0] loop_counter, // repeat counter
  input wire logic [3:0] stack_pointer, // stack pointer
  input wire logic [4:0] stack_depth_counter, // stack depth
  input wire logic core_clk_en, // clock gate
  input wire logic debug_mode, // debug state
  input wire logic [7:0] pending_ack // pending clear pulses
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic vec_word;
  logic vec_ack;
  logic push;
  assign vec_ack = fetch_from_vector && fetch_ack;
  assign push = exec_jsr && jsr_from_slot;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) vec_word <= 1'b0;
    else if (vec_ack) vec_word <= ~vec_word;
  end
  a_vec_second: assert property (vec_ack && !vec_word |=>
    fetch_from_vector && fetch_addr == $past(fetch_addr) + 24'h00_0001)
    else $error("second vector word address wrong");
  a_vec_return: assert property (vec_ack && vec_word |=>
    !fetch_from_vector && fetch_addr == program_counter)
    else $error("fetch did not return to counter");
  a_pc_hold: assert property (fetch_from_vector ##1 fetch_from_vector |->
    $stable(program_counter)) else $error("counter moved during vector fetch");
  a_pend_clear: assert property (vec_ack && vec_word |=> $onehot(pending_ack))
    else $error("pending flag not cleared after second word");
  a_stack_only: assert property ($changed(stack_pointer) |->
    $past(push || exec_rti)) else $error("stack moved without long jump or return");
  a_mask_only: assert property ($changed(processor_status_word[9:8]) |->
    $past(push || exec_rti)) else $error("mask changed without long jump");
  a_long_clear: assert property (push |=> !processor_status_word[15] &&
    processor_status_word[11:10] == 2'b00) else $error("loop or scale not cleared");
  a_push_depth: assert property (push |=>
    stack_depth_counter == $past(stack_depth_counter) + 5'h01)
    else $error("depth not raised by long jump");
  a_rti_depth: assert property (exec_rti |=>
    stack_depth_counter == $past(stack_depth_counter) - 5'h01)
    else $error("depth not lowered by return");
  a_wait_gate: assert property (exec_wait |=> !core_clk_en)
    else $error("clock not gated by wait");
  a_break_debug: assert property (!core_clk_en && !emulation_break_pin_n |->
    ##[1:4] debug_mode) else $error("break did not enter debug");
  a_rep_hold: assert property (loop_counter > 24'h00_0001 |=>
    !$rose(fetch_from_vector)) else $error("interrupt taken inside repeat");
  c_fast: cover property (vec_ack && vec_word);
  c_long: cover property (push);
  c_debug: cover property ($rose(debug_mode));
endmodule // idc_core_asserts
bind idc_core idc_core_asserts u_chk (.clk_sys, .rst_n, .emulation_break_pin_n,
  .fetch_ack, .exec_jsr, .jsr_from_slot, .exec_rti, .exec_wait, .fetch_addr,
  .fetch_from_vector, .program_counter, .processor_status_word, .loop_counter,
  .stack_pointer, .stack_depth_counter, .core_clk_en, .debug_mode, .pending_ack);
`default_nettype wire

/* File: bench/idc_pipe_model.sv */
// Purpose: fetch and decode pipeline facing the dispatch unit
// Assumes: one instruction per consumed fetch
// Notes: slow mode consumes a fetch only every other cycle
`timescale 1ns/1ps
`default_nettype none
module idc_pipe_model (
  input wire logic clk_sys, // core clock
  input wire logic rst_n, // reset, active low
  input wire logic slow, // stall every other cycle
  input wire logic core_clk_en, // core running
  input wire logic fetch_from_vector, // vector word in flight
  input wire logic [23:0] program_counter, // current counter
  output logic fetch_ack, // fetch consumed
  output logic instr_done, // instruction finished
  output logic pc_load, // counter advance
  output logic [23:0] next_pc_in // next counter value
);
  logic phase;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) phase <= 1'b0;
    else phase <= ~phase;
  end
  assign fetch_ack = core_clk_en && (!slow || phase);
  assign instr_done = fetch_ack;
  // never asks for a counter update on a vector word
  assign pc_load = fetch_ack && !fetch_from_vector;
  assign next_pc_in = program_counter + 24'h00_0001;
endmodule // idc_pipe_model
`default_nettype wire

/* File: bench/test_idc_core.sv */
// Purpose: directed test of vector insertion and core states
// Assumes: all sources nonmaskable so the reset mask admits them
// Notes: jump and return pulses stand in for the decoder
`timescale 1ns/1ps
`default_nettype none
module test_idc_core;
  logic clk_sys, rst_n, emulation_break_pin_n, slow, fetch_ack, instr_done, pc_load;
  logic exec_jsr, jsr_from_slot, exec_rti, exec_wait, exec_rep, slot_two_word;
  logic prio_core_we, vbase_we, fetch_from_vector, periph_rst, core_clk_en, debug_mode;
  logic [3:0] boot_select_pins, stack_pointer;
  logic [4:0] discard_cnt, stack_depth_counter;
  logic [7:0] irq_req, prio_core_wr, core_priority_register, peripheral_priority_register;
  logic [7:0] pending_ack;
  logic [15:0] irq_ipl;
  logic [23:0] rep_count, next_pc_in, vbase_wr, fetch_addr, program_counter;
  logic [23:0] processor_status_word, operating_mode_register, loop_counter;
  logic [23:0] vector_base_register, bus_timing_control, address_attribute_regs;
  logic [23:0] dram_timing_control, address_modifier_regs, sw;
  int num_errors = 0;
  int checked = 0;
  idc_core uut (.clk_sys, .rst_n, .boot_select_pins, .emulation_break_pin_n, .irq_req,
    .irq_ipl, .fetch_ack, .instr_done, .exec_jsr, .jsr_from_slot, .exec_rti, .exec_wait,
    .exec_rep, .rep_count, .slot_two_word, .next_pc_in, .pc_load, .prio_core_wr,
    .prio_core_we, .vbase_wr, .vbase_we, .fetch_addr, .fetch_from_vector,
    .program_counter, .processor_status_word, .operating_mode_register, .loop_counter,
    .discard_cnt, .stack_pointer, .stack_depth_counter, .vector_base_register,
    .core_priority_register, .peripheral_priority_register, .bus_timing_control,
    .address_attribute_regs, .dram_timing_control, .address_modifier_regs,
    .periph_rst, .core_clk_en, .debug_mode, .pending_ack);
  idc_pipe_model pipe (.clk_sys, .rst_n, .slow, .core_clk_en, .fetch_from_vector,
    .program_counter, .fetch_ack, .instr_done, .pc_load, .next_pc_in);
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task lim(input int i);
    if (i >= 60) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task wait_vec(input logic lvl);
    int i;
    for (i = 0; i < 60 && fetch_from_vector !== lvl; i++) @(posedge clk_sys) #1;
    lim(i);
  endtask
  task do_reset(input logic [3:0] pins);
    @(posedge clk_sys) rst_n <= 0;
    boot_select_pins <= pins;
    repeat (6) @(posedge clk_sys);
    #1 chk("periph reset", 24'h00_0001, {23'h0, periph_rst});
    chk("modifiers", 24'h0F_FFFF, address_modifier_regs);
    chk("status", 24'h00_0300, processor_status_word);
    chk("stack", 24'h00_0000, {15'h0, stack_depth_counter, stack_pointer});
    chk("vector base", 24'h00_0000, vector_base_register);
    chk("priorities", 24'h00_0000, {8'h0, core_priority_register, peripheral_priority_register});
    chk("bus timing", idc_pkg::BUS_TIMING_RESET, bus_timing_control);
    @(posedge clk_sys) rst_n <= 1;
    repeat (3) @(posedge clk_sys);
    #1 chk("mode", {20'h0, pins}, {16'h0, operating_mode_register[7:0]});
  endtask
  task pulse_cmd(input int k);
    @(posedge clk_sys) {exec_jsr, jsr_from_slot, exec_rti, exec_wait} <=
      (k == 0) ? 4'b1100 : 4'(4'b1000 >> k);
    @(posedge clk_sys) {exec_jsr, jsr_from_slot, exec_rti, exec_wait} <= 4'h0;
    #1;
  endtask
  task irq_run(input int src, input logic long_form);
    logic [23:0] v, pc;
    int i;
    v = vector_base_register + 24'(2 * src);
    @(posedge clk_sys) irq_req[src] <= 1;
    wait_vec(1);
    pc = program_counter;
    irq_req[src] <= 0;
    chk("first vector", v, fetch_addr);
    for (i = 0; i < 60 && fetch_addr === v; i++) @(posedge clk_sys) #1;
    lim(i);
    chk("second vector", v + 24'h00_0001, fetch_addr);
    chk("held counter", pc, program_counter);
    wait_vec(0);
    chk("resume", pc, fetch_addr);
    chk("pending clear", 24'h00_0001 << src, {16'h0, pending_ack});
    chk("no save", 24'h00_0000, {19'h0, stack_depth_counter});
    if (long_form) begin
      sw = processor_status_word;
      pulse_cmd(0);
      chk("pushed", 24'h00_0001, {19'h0, stack_depth_counter});
      chk("loop scale", 24'h00_0000,
        {21'h0, processor_status_word[15], processor_status_word[11:10]});
      pulse_cmd(2);
      chk("popped", 24'h00_0000, {19'h0, stack_depth_counter});
      chk("status back", sw, processor_status_word);
    end
  endtask
  initial begin
    int i;
    {rst_n, slow, exec_jsr, jsr_from_slot, exec_rti, exec_wait, exec_rep} = 0;
    {slot_two_word, prio_core_we, vbase_we, irq_req, prio_core_wr} = 0;
    {emulation_break_pin_n, boot_select_pins, irq_ipl} = {1'b1, 4'h0, 16'hFFFF};
    {rep_count, vbase_wr} = 0;
    do_reset(4'h5);
    @(posedge clk_sys) {vbase_we, vbase_wr, prio_core_we, prio_core_wr} <= {1'b1, 24'h00_0100, 1'b1, 8'h5A};
    @(posedge clk_sys) {vbase_we, prio_core_we} <= 2'b00;
    #1 chk("base write", 24'h00_0100, vector_base_register);
    for (i = 0; i < 8; i++) begin
      slow <= i[0];
      irq_run(i, i[1]);
    end
    @(posedge clk_sys) {exec_rep, rep_count, irq_req[3]} <= {1'b1, 24'h00_0005, 1'b1};
    @(posedge clk_sys) exec_rep <= 0;
    repeat (2) @(posedge clk_sys);
    #1 chk("repeat holds", 24'h00_0000, {23'h0, fetch_from_vector});
    wait_vec(1);
    irq_req[3] <= 0;
    wait_vec(0);
    pulse_cmd(3);
    chk("wait gated", 24'h00_0000, {23'h0, core_clk_en});
    @(posedge clk_sys) irq_req[4] <= 1;
    wait_vec(1);
    irq_req[4] <= 0;
    wait_vec(0);
    pulse_cmd(3);
    @(posedge clk_sys) emulation_break_pin_n <= 0;
    for (i = 0; i < 60 && debug_mode !== 1'b1; i++) @(posedge clk_sys) #1;
    lim(i);
    chk("debug", 24'h00_0001, {23'h0, debug_mode});
    @(posedge clk_sys) emulation_break_pin_n <= 1;
    do_reset(4'hA);
    wrap_up();
  end
endmodule // test_idc_core
`default_nettype wire
